// *** core/camera_dma_defs.svh ***
// register offsets, field positions and reset values of the camera dma block
`ifndef CAMERA_DMA_DEFS_SVH
`define CAMERA_DMA_DEFS_SVH

`define CODEC_DMA_TARGET_AREA_ADDR     32'h4f00_005c
`define CODEC_PATH_STATUS_ADDR         32'h4f00_0064
`define PREVIEW_FRAME1_START_ADDR_ADDR 32'h4f00_006c
`define PREVIEW_FRAME2_START_ADDR_ADDR 32'h4f00_0070
`define PREVIEW_FRAME3_START_ADDR_ADDR 32'h4f00_0074
`define PREVIEW_FRAME4_START_ADDR_ADDR 32'h4f00_0078
`define PREVIEW_TARGET_FORMAT_ADDR     32'h4f00_007c
`define PREVIEW_DMA_CONTROL_ADDR       32'h4f00_0080
`define PREVIEW_PRESCALE_RATIO_ADDR    32'h4f00_0084
`define IRQ_STATUS_ADDR                32'h4f00_00b0
`define IRQ_MASK_ADDR                  32'h4f00_00b4
`define PATH_CONFIG_ADDR               32'h4f00_00b8

`define REG_RESET 32'h0000_0000

// codec path status fields
`define CST_LUMA_OVF_BIT    31
`define CST_BLUE_OVF_BIT    30
`define CST_RED_OVF_BIT     29
`define CST_VSYNC_BIT       28
`define CST_FRAME_CNT_MSB   27
`define CST_FRAME_CNT_LSB   26
`define CST_WIN_OFS_BIT     25
`define CST_FLIP_MSB        24
`define CST_FLIP_LSB        23
`define CST_IF_CAPTURE_BIT  22
`define CST_CODEC_CAPTURE_BIT 21

// preview target format fields
`define TFMT_WIDTH_MSB  28
`define TFMT_WIDTH_LSB  16
`define TFMT_FLIP_MSB   15
`define TFMT_FLIP_LSB   14
`define TFMT_HEIGHT_MSB 12
`define TFMT_HEIGHT_LSB 0

// preview dma control fields
`define DCTL_MAIN_MSB 23
`define DCTL_MAIN_LSB 19
`define DCTL_REM_MSB  18
`define DCTL_REM_LSB  14
`define DCTL_ARM_BIT  2

// preview prescale fields
`define PSR_SHIFT_MSB 31
`define PSR_SHIFT_LSB 28
`define PSR_HOR_MSB   22
`define PSR_HOR_LSB   16
`define PSR_VER_MSB   6
`define PSR_VER_LSB   0

// interrupt status bits
`define IRQ_FRAME_END_BIT  0
`define IRQ_LAST_FRAME_BIT 1
`define IRQ_CODEC_OVF_BIT  2
`define IRQ_BITS           3

// path config bits
`define CFG_RGB32_BIT 0

`endif

// *** core/camera_dma_pkg.sv ***
// types shared by the camera dma block
package camera_dma_pkg;

  typedef enum logic [1:0] {
    DMA_IDLE  = 2'b00,
    DMA_NEXT  = 2'b01,
    DMA_BURST = 2'b10
  } dma_state_type;

  typedef enum logic [1:0] {
    FLIP_NORMAL   = 2'b00,
    FLIP_X_MIRROR = 2'b01,
    FLIP_Y_MIRROR = 2'b10,
    FLIP_ROTATE   = 2'b11
  } flip_mode_type;

endpackage

// *** core/camera_dma_scaler_config.sv ***
// camera dma register slice: codec status, preview frame dma and prescale settings
// What this block does
// - codec area register feeds codec dma area
// - codec status shows three fifo overflow flags
// - codec status bit 28 mirrors vsync
// - codec frame counter shows next frame number
// - status shows window offset, flip, capture enables
// - four readable writable preview frame start addresses
// - preview height held in bits 12:0
// - preview flip field selects memory write order
// - main and remainder burst lengths in control
// - armed last irq fires at frame end, self-clears
// - 32-bit rgb one pixel, 16-bit two per word
// - prescale shift, horizontal and vertical ratio fields
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "camera_dma_defs.svh"

module camera_dma_scaler_config (
  input  wire logic        clk_i,              // 100 MHz clock
  input  wire logic        resetn_i,           // async reset, active low
  input  wire logic [31:0] addr_i,             // register byte address
  input  wire logic [31:0] wdata_i,            // write data
  input  wire logic        wr_i,               // write strobe
  input  wire logic        rd_i,               // read strobe
  output logic      [31:0] rdata_o,            // read data, cycle after rd_i
  output logic             irq_o,              // level interrupt
  input  wire logic [2:0]  codec_fifo_overflow_i, // luma, blue, red overflow
  input  wire logic        cam_vsync_i,        // camera vertical sync
  input  wire logic        codec_window_offset_on_i, // window offset state
  input  wire logic [1:0]  codec_flip_setting_i,     // codec flip mode
  input  wire logic        interface_capture_on_i,   // interface capture enable
  input  wire logic        codec_path_capture_on_i,  // codec capture enable
  input  wire logic        codec_frame_done_i, // codec frame written, pulse
  input  wire logic        preview_frame_start_i, // preview frame begins, pulse
  input  wire logic        burst_ready_i,      // memory takes the burst
  output logic             burst_valid_o,      // burst request
  output logic      [31:0] burst_addr_o,       // burst byte address
  output logic      [4:0]  burst_len_o,        // burst length in words
  output logic             burst_reverse_o,    // burst written high to low
  output logic      [1:0]  preview_frame_count_o, // next preview frame
  output logic      [25:0] codec_frame_area_o, // codec per-frame pixel area
  output logic      [3:0]  prescale_shift_value_o, // prescale shift
  output logic      [6:0]  prescale_horiz_ratio_o, // prescale horizontal ratio
  output logic      [6:0]  prescale_vert_ratio_o   // prescale vertical ratio
);

  // software visible state
  logic [25:0] codec_dma_target_area_q;
  logic [31:0] start_addr_q [4];
  logic [12:0] preview_target_width_q;
  logic [12:0] preview_target_height_q;
  logic [1:0]  preview_flip_setting_q;
  logic [4:0]  preview_main_burst_len_q;
  logic [4:0]  preview_remainder_burst_len_q;
  logic        preview_last_frame_irq_arm_q;
  logic [31:0] preview_prescale_ratio_q;
  logic [2:0]  irq_status_q;
  logic [2:0]  irq_status_d;
  logic [2:0]  irq_mask_q;
  logic        rgb32_q;
  logic [1:0]  codec_next_frame_number_q;
  logic [2:0]  ovf_prev_q;

  // dma engine state
  camera_dma_pkg::dma_state_type state_q;
  logic [1:0]  pv_frame_q;
  logic [31:0] base_q;
  logic [12:0] line_q, off_q, left_q, lw_q, lh_q;
  logic [4:0]  main_q;
  logic [1:0]  flip_q;

  logic        wr_hit_ctl;
  logic        rd_status;
  logic        frame_end;
  logic        ovf_event;
  logic [12:0] line_words, main_ext, rem_words, next_len, row, word_idx;
  logic [25:0] row_words, word_off;
  logic [31:0] next_addr;
  logic [31:0] codec_status;
  logic [31:0] read_value;

  // line length in words from the pixel format
  assign line_words = rgb32_q ? preview_target_width_q : (preview_target_width_q >> 1);

  // remainder: line words masked with main minus one (modulo only for a power-of-two main), main when zero
  assign main_ext  = {8'h00, main_q};
  assign rem_words = ((lw_q & (main_ext - 13'h0001)) == 13'h0000) ? main_ext
                     : (lw_q & (main_ext - 13'h0001));
  assign next_len  = (left_q == rem_words) ? rem_words : main_ext;

  // write order from flip mode
  assign row = flip_q[0] ? (lh_q - 13'h0001 - line_q) : line_q;
  assign word_idx = flip_q[1] ? (lw_q - off_q - next_len) : off_q;
  assign row_words = row * lw_q;
  assign word_off  = row_words + {13'h0000, word_idx};
  assign next_addr = base_q + {4'h0, word_off, 2'b00}; // word offset to byte address, 32 bits exactly

  assign frame_end = (state_q == camera_dma_pkg::DMA_BURST) && burst_ready_i
                     && (left_q == {8'h00, burst_len_o}) && (line_q == lh_q - 13'h0001);
  assign ovf_event = |(codec_fifo_overflow_i & ~ovf_prev_q);
  assign wr_hit_ctl = wr_i && (addr_i == `PREVIEW_DMA_CONTROL_ADDR);
  assign rd_status  = rd_i && (addr_i == `IRQ_STATUS_ADDR);

  // codec status word
  always_comb begin
    codec_status = `REG_RESET;
    codec_status[`CST_LUMA_OVF_BIT] = codec_fifo_overflow_i[2];
    codec_status[`CST_BLUE_OVF_BIT] = codec_fifo_overflow_i[1];
    codec_status[`CST_RED_OVF_BIT]  = codec_fifo_overflow_i[0];
    codec_status[`CST_VSYNC_BIT]    = cam_vsync_i;
    codec_status[`CST_FRAME_CNT_MSB:`CST_FRAME_CNT_LSB] = codec_next_frame_number_q;
    codec_status[`CST_WIN_OFS_BIT]  = codec_window_offset_on_i;
    codec_status[`CST_FLIP_MSB:`CST_FLIP_LSB] = codec_flip_setting_i;
    codec_status[`CST_IF_CAPTURE_BIT] = interface_capture_on_i;
    codec_status[`CST_CODEC_CAPTURE_BIT] = codec_path_capture_on_i;
  end

  // read multiplexer, unmapped reads give zero
  always_comb begin
    read_value = `REG_RESET;
    unique case (addr_i)
      `CODEC_DMA_TARGET_AREA_ADDR:     read_value = {6'h00, codec_dma_target_area_q};
      `CODEC_PATH_STATUS_ADDR:         read_value = codec_status;
      `PREVIEW_FRAME1_START_ADDR_ADDR: read_value = start_addr_q[0];
      `PREVIEW_FRAME2_START_ADDR_ADDR: read_value = start_addr_q[1];
      `PREVIEW_FRAME3_START_ADDR_ADDR: read_value = start_addr_q[2];
      `PREVIEW_FRAME4_START_ADDR_ADDR: read_value = start_addr_q[3];
      `PREVIEW_TARGET_FORMAT_ADDR: begin
        read_value[`TFMT_WIDTH_MSB:`TFMT_WIDTH_LSB]   = preview_target_width_q;
        read_value[`TFMT_FLIP_MSB:`TFMT_FLIP_LSB]     = preview_flip_setting_q;
        read_value[`TFMT_HEIGHT_MSB:`TFMT_HEIGHT_LSB] = preview_target_height_q;
      end
      `PREVIEW_DMA_CONTROL_ADDR: begin
        read_value[`DCTL_MAIN_MSB:`DCTL_MAIN_LSB] = preview_main_burst_len_q;
        read_value[`DCTL_REM_MSB:`DCTL_REM_LSB]   = preview_remainder_burst_len_q;
        read_value[`DCTL_ARM_BIT]                 = preview_last_frame_irq_arm_q;
      end
      `PREVIEW_PRESCALE_RATIO_ADDR: read_value = preview_prescale_ratio_q;
      `IRQ_STATUS_ADDR:  read_value = {29'h0000_0000, irq_status_q};
      `IRQ_MASK_ADDR:    read_value = {29'h0000_0000, irq_mask_q};
      `PATH_CONFIG_ADDR: read_value = {31'h0000_0000, rgb32_q};
      default:           read_value = `REG_RESET;
    endcase
  end

  // read data stands one cycle only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `REG_RESET;
    end else begin
      rdata_o <= rd_i ? read_value : `REG_RESET;
    end
  end

  // plain read-write registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      codec_dma_target_area_q       <= 26'h000_0000;
      start_addr_q[0]               <= `REG_RESET;
      start_addr_q[1]               <= `REG_RESET;
      start_addr_q[2]               <= `REG_RESET;
      start_addr_q[3]               <= `REG_RESET;
      preview_target_width_q        <= 13'h0000;
      preview_target_height_q       <= 13'h0000;
      preview_flip_setting_q        <= 2'h0;
      preview_main_burst_len_q      <= 5'h00;
      preview_remainder_burst_len_q <= 5'h00;
      preview_prescale_ratio_q      <= `REG_RESET;
      irq_mask_q                    <= 3'h0;
      rgb32_q                       <= 1'b0;
    end else if (wr_i) begin
      unique case (addr_i)
        `CODEC_DMA_TARGET_AREA_ADDR:     codec_dma_target_area_q <= wdata_i[25:0];
        `PREVIEW_FRAME1_START_ADDR_ADDR: start_addr_q[0] <= wdata_i;
        `PREVIEW_FRAME2_START_ADDR_ADDR: start_addr_q[1] <= wdata_i;
        `PREVIEW_FRAME3_START_ADDR_ADDR: start_addr_q[2] <= wdata_i;
        `PREVIEW_FRAME4_START_ADDR_ADDR: start_addr_q[3] <= wdata_i;
        `PREVIEW_TARGET_FORMAT_ADDR: begin
          preview_target_width_q  <= wdata_i[`TFMT_WIDTH_MSB:`TFMT_WIDTH_LSB];
          preview_flip_setting_q  <= wdata_i[`TFMT_FLIP_MSB:`TFMT_FLIP_LSB];
          preview_target_height_q <= wdata_i[`TFMT_HEIGHT_MSB:`TFMT_HEIGHT_LSB];
        end
        `PREVIEW_DMA_CONTROL_ADDR: begin
          preview_main_burst_len_q      <= wdata_i[`DCTL_MAIN_MSB:`DCTL_MAIN_LSB];
          preview_remainder_burst_len_q <= wdata_i[`DCTL_REM_MSB:`DCTL_REM_LSB];
        end
        `PREVIEW_PRESCALE_RATIO_ADDR: preview_prescale_ratio_q <= wdata_i;
        `IRQ_MASK_ADDR:    irq_mask_q <= wdata_i[2:0];
        `PATH_CONFIG_ADDR: rgb32_q    <= wdata_i[`CFG_RGB32_BIT];
        default: ;
      endcase
    end
  end

  // last-frame arm: software write wins, else frame end clears it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      preview_last_frame_irq_arm_q <= 1'b0;
    end else if (wr_hit_ctl) begin
      preview_last_frame_irq_arm_q <= wdata_i[`DCTL_ARM_BIT];
    end else if (frame_end) begin
      preview_last_frame_irq_arm_q <= 1'b0;
    end
  end

  // codec frame counter points at the next frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      codec_next_frame_number_q <= 2'h0;
      ovf_prev_q                <= 3'h0;
    end else begin
      ovf_prev_q <= codec_fifo_overflow_i;
      if (codec_frame_done_i) begin
        codec_next_frame_number_q <= codec_next_frame_number_q + 2'h1;
      end
    end
  end

  // sticky events, set beats read clear
  always_comb begin
    irq_status_d = rd_status ? 3'h0 : irq_status_q;
    if (frame_end) begin
      irq_status_d[`IRQ_FRAME_END_BIT] = 1'b1;
    end
    if (frame_end && preview_last_frame_irq_arm_q) begin
      irq_status_d[`IRQ_LAST_FRAME_BIT] = 1'b1;
    end
    if (ovf_event) begin
      irq_status_d[`IRQ_CODEC_OVF_BIT] = 1'b1;
    end
  end

  // interrupt status and output
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_q <= 3'h0;
      irq_o        <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_o        <= |(irq_status_d & irq_mask_q);
    end
  end

  // setting outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      codec_frame_area_o     <= 26'h000_0000;
      prescale_shift_value_o <= 4'h0;
      prescale_horiz_ratio_o <= 7'h00;
      prescale_vert_ratio_o  <= 7'h00;
    end else begin
      codec_frame_area_o     <= codec_dma_target_area_q;
      prescale_shift_value_o <= preview_prescale_ratio_q[`PSR_SHIFT_MSB:`PSR_SHIFT_LSB];
      prescale_horiz_ratio_o <= preview_prescale_ratio_q[`PSR_HOR_MSB:`PSR_HOR_LSB];
      prescale_vert_ratio_o  <= preview_prescale_ratio_q[`PSR_VER_MSB:`PSR_VER_LSB];
    end
  end

  // preview dma: frame, line and burst sequencing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q         <= camera_dma_pkg::DMA_IDLE;
      pv_frame_q      <= 2'h0;
      base_q          <= `REG_RESET;
      line_q          <= 13'h0000;
      off_q           <= 13'h0000;
      left_q          <= 13'h0000;
      lw_q            <= 13'h0000;
      lh_q            <= 13'h0000;
      main_q          <= 5'h00;
      flip_q          <= 2'h0;
      burst_valid_o   <= 1'b0;
      burst_addr_o    <= `REG_RESET;
      burst_len_o     <= 5'h00;
      burst_reverse_o <= 1'b0;
    end else begin
      unique case (state_q)
        camera_dma_pkg::DMA_IDLE: begin
          if (preview_frame_start_i && (line_words != 13'h0000)
              && (preview_target_height_q != 13'h0000)) begin
            base_q  <= start_addr_q[pv_frame_q];
            lw_q    <= line_words;
            lh_q    <= preview_target_height_q;
            main_q  <= preview_main_burst_len_q;
            flip_q  <= preview_flip_setting_q;
            line_q  <= 13'h0000;
            off_q   <= 13'h0000;
            left_q  <= line_words;
            state_q <= camera_dma_pkg::DMA_NEXT;
          end
        end
        camera_dma_pkg::DMA_NEXT: begin
          burst_addr_o    <= next_addr;
          burst_len_o     <= next_len[4:0];
          burst_reverse_o <= flip_q[1];
          burst_valid_o   <= 1'b1;
          state_q         <= camera_dma_pkg::DMA_BURST;
        end
        camera_dma_pkg::DMA_BURST: begin
          if (burst_ready_i) begin
            burst_valid_o <= 1'b0;
            if (left_q == {8'h00, burst_len_o}) begin
              if (frame_end) begin
                pv_frame_q <= pv_frame_q + 2'h1;
                state_q    <= camera_dma_pkg::DMA_IDLE;
              end else begin
                line_q  <= line_q + 13'h0001;
                off_q   <= 13'h0000;
                left_q  <= lw_q;
                state_q <= camera_dma_pkg::DMA_NEXT;
              end
            end else begin
              off_q   <= off_q + {8'h00, burst_len_o};
              left_q  <= left_q - {8'h00, burst_len_o};
              state_q <= camera_dma_pkg::DMA_NEXT;
            end
          end
        end
        default: state_q <= camera_dma_pkg::DMA_IDLE;
      endcase
    end
  end

  // frame count out
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      preview_frame_count_o <= 2'h0;
    end else begin
      preview_frame_count_o <= pv_frame_q;
    end
  end

  // checks on the design's own outputs and internal state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_read_area;
    rd_i && (addr_i == `CODEC_DMA_TARGET_AREA_ADDR);
  endsequence
  sequence s_read_codec_status;
    rd_i && (addr_i == `CODEC_PATH_STATUS_ADDR);
  endsequence
  sequence s_armed_frame_end;
    frame_end && preview_last_frame_irq_arm_q && !wr_hit_ctl;
  endsequence

  property p_codec_area;
    s_read_area |=> (rdata_o[25:0] == codec_dma_target_area_q) && (rdata_o[31:26] == 6'h00);
  endproperty
  a_codec_area: assert property (p_codec_area) else $error("codec area readback wrong");

  property p_overflow_flags;
    s_read_codec_status |=> (rdata_o[31:29] == $past(codec_fifo_overflow_i));
  endproperty
  a_overflow_flags: assert property (p_overflow_flags) else $error("overflow flags wrong");

  property p_vsync_mirror;
    s_read_codec_status |=> (rdata_o[28] == $past(cam_vsync_i));
  endproperty
  a_vsync_mirror: assert property (p_vsync_mirror) else $error("vsync mirror wrong");

  property p_codec_count;
    codec_frame_done_i |=> (codec_next_frame_number_q == $past(codec_next_frame_number_q) + 2'h1);
  endproperty
  a_codec_count: assert property (p_codec_count) else $error("codec frame count not advanced");

  property p_last_irq;
    s_armed_frame_end |=> !preview_last_frame_irq_arm_q && irq_status_q[`IRQ_LAST_FRAME_BIT];
  endproperty
  a_last_irq: assert property (p_last_irq) else $error("last frame irq not raised");

  property p_remainder_last;
    burst_valid_o && (left_q == {8'h00, burst_len_o}) |-> ({8'h00, burst_len_o} == rem_words);
  endproperty
  a_remainder_last: assert property (p_remainder_last) else $error("line tail not remainder");

  property p_burst_hold;
    burst_valid_o && !burst_ready_i |=> burst_valid_o && $stable(burst_addr_o) && $stable(burst_len_o);
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst dropped before accept");

  property p_frame_base;
    (state_q == camera_dma_pkg::DMA_IDLE) && preview_frame_start_i && (line_words != 13'h0000)
      && (preview_target_height_q != 13'h0000) |=> (base_q == $past(start_addr_q[pv_frame_q]));
  endproperty
  a_frame_base: assert property (p_frame_base) else $error("wrong frame buffer selected");

  property p_irq_level;
    ##1 irq_o == |(irq_status_q & $past(irq_mask_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

endmodule

// *** test/burst_memory_model.sv ***
// memory side of the burst link, answering promptly or with stalls
`timescale 1ns/10ps
module burst_memory_model (
  input  wire logic clk_i,    // bench clock
  input  wire logic resetn_i, // async reset, active low
  input  wire logic valid_i,  // burst request from the dma
  input  wire logic slow_i,   // stall two cycles in three
  output logic      ready_o   // burst taken this cycle
);
  logic [1:0] phase_q;
  // free-running stall phase, so a slow memory answers only every third cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    end
  end
  // accept only a pending request, and only on the open phase when slow
  assign ready_o = valid_i && (!slow_i || phase_q == 2'h2);
endmodule

// *** test/camera_dma_scaler_config_bench.sv ***
// self-checking bench for the camera dma register slice
`timescale 1ns/10ps
`include "camera_dma_defs.svh"
module camera_dma_scaler_config_bench;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, vs = 0, wof = 0, ifc = 0, cdc = 0, cdone = 0, pstart = 0;
  logic        rdy, bv, brev, irq, slow = 0;
  logic [31:0] addr = 0, wd = 0, rdat, badr;
  logic [2:0]  ovf = 0;
  logic [1:0]  cflip = 0, pcnt;
  logic [4:0]  blen;
  logic [25:0] area;
  logic [3:0]  shf;
  logic [6:0]  hr, vr;
  int          fail_count = 0, checks = 0;
  logic [31:0] sa [4] = '{32'h1000_0000, 32'h2000_0400, 32'h3000_0800, 32'h4000_0c00};

  // 100 MHz clock
  always #5 clk = ~clk;

  camera_dma_scaler_config dut (
    .clk_i(clk), .resetn_i(rstn), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .irq_o(irq), .codec_fifo_overflow_i(ovf), .cam_vsync_i(vs), .codec_window_offset_on_i(wof),
    .codec_flip_setting_i(cflip), .interface_capture_on_i(ifc), .codec_path_capture_on_i(cdc),
    .codec_frame_done_i(cdone), .preview_frame_start_i(pstart), .burst_ready_i(rdy), .burst_valid_o(bv),
    .burst_addr_o(badr), .burst_len_o(blen), .burst_reverse_o(brev), .preview_frame_count_o(pcnt),
    .codec_frame_area_o(area), .prescale_shift_value_o(shf), .prescale_horiz_ratio_o(hr),
    .prescale_vert_ratio_o(vr));

  burst_memory_model mem (.clk_i(clk), .resetn_i(rstn), .valid_i(bv), .slow_i(slow), .ready_o(rdy));

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask

  task automatic rreg(string n, logic [31:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(n, e, rdat);
  endtask

  // one-cycle pulse: 0 codec frame done, 1 preview frame start
  task automatic pulse(int w);
    @(posedge clk);
    if (w == 0) cdone <= 1; else pstart <= 1;
    @(posedge clk);
    cdone <= 0;
    pstart <= 0;
  endtask

  task automatic t_regs();
    rreg("area reset", `CODEC_DMA_TARGET_AREA_ADDR, `REG_RESET);
    wreg(`CODEC_DMA_TARGET_AREA_ADDR, 32'hffff_ffff);
    rreg("area", `CODEC_DMA_TARGET_AREA_ADDR, 32'h03ff_ffff);
    chk("area out", 32'h03ff_ffff, {6'h0, area});
    for (int i = 0; i < 4; i++) wreg(`PREVIEW_FRAME1_START_ADDR_ADDR + 4 * i, sa[i]);
    for (int i = 0; i < 4; i++) rreg("start addr", `PREVIEW_FRAME1_START_ADDR_ADDR + 4 * i, sa[i]);
    wreg(`PREVIEW_TARGET_FORMAT_ADDR, 32'hfffe_ffff);
    rreg("format", `PREVIEW_TARGET_FORMAT_ADDR, 32'h1ffe_dfff);
    wreg(`PREVIEW_DMA_CONTROL_ADDR, 32'h0084_0000);
    rreg("control", `PREVIEW_DMA_CONTROL_ADDR, 32'h0084_0000);
    // ratios 4 and 2, so shift is 10 - (2 + 1)
    wreg(`PREVIEW_PRESCALE_RATIO_ADDR, 32'h7004_0002);
    rreg("prescale", `PREVIEW_PRESCALE_RATIO_ADDR, 32'h7004_0002);
    chk("prescale out", {14'h0, 4'h7, 7'h4, 7'h2}, {14'h0, shf, hr, vr});
    rreg("unmapped", 32'h4f00_0060, 32'h0);
    $display("register test done");
  endtask

  task automatic t_status();
    wreg(`IRQ_MASK_ADDR, 32'h7);
    wreg(`CODEC_PATH_STATUS_ADDR, 32'hffff_ffff);
    rreg("status idle", `CODEC_PATH_STATUS_ADDR, 32'h0);
    @(posedge clk);
    ovf <= 3'b101;
    vs <= 1;
    wof <= 1;
    cflip <= 2'b10;
    ifc <= 1;
    for (int i = 0; i < 3; i++) pulse(0);
    rreg("status a", `CODEC_PATH_STATUS_ADDR, 32'hbf40_0000);
    chk("irq ovf", 1, irq);
    rreg("irq status ovf", `IRQ_STATUS_ADDR, 32'h4);
    repeat (2) @(negedge clk);
    chk("irq cleared", 0, irq);
    @(posedge clk);
    ovf <= 3'b010;
    vs <= 0;
    wof <= 0;
    cflip <= 2'b01;
    ifc <= 0;
    cdc <= 1;
    pulse(0);
    rreg("status b", `CODEC_PATH_STATUS_ADDR, 32'h40a0_0000);
    rreg("irq status b", `IRQ_STATUS_ADDR, 32'h4);
    $display("status test done");
  endtask

  // frame of 2 lines, 6 words each, main burst 4 so remainder 2
  task automatic t_frame(int k, logic [1:0] fl, logic wide);
    int n = 0, t = 0, r, w;
    @(posedge clk);
    slow <= wide;
    wreg(`PATH_CONFIG_ADDR, {31'h0, wide});
    wreg(`PREVIEW_TARGET_FORMAT_ADDR, {3'h0, wide ? 13'd6 : 13'd12, fl, 14'd2});
    wreg(`PREVIEW_DMA_CONTROL_ADDR, {8'h0, 5'd4, 5'd2, 11'h0, wide, 2'h0});
    pulse(1);
    while (n < 4 && t < 200) begin
      @(negedge clk);
      t++;
      if (bv && rdy) begin
        r = fl[0] ? 1 - n / 2 : n / 2;
        w = n % 2;
        chk("burst addr", sa[k] + 4 * (r * 6 + (fl[1] ? (w ? 0 : 2) : (w ? 4 : 0))), badr);
        chk("burst len", w ? 2 : 4, {27'h0, blen});
        chk("burst reverse", {31'h0, fl[1]}, {31'h0, brev});
        n++;
      end
    end
    chk("burst count", 4, n);
    repeat (3) @(negedge clk);
    chk("irq frame", 1, irq);
    rreg("irq status frame", `IRQ_STATUS_ADDR, {30'h0, wide, 1'b1});
    rreg("control after", `PREVIEW_DMA_CONTROL_ADDR, {8'h0, 5'd4, 5'd2, 14'h0});
    chk("frame count", (k + 1) % 4, {30'h0, pcnt});
    $display("frame %0d done", k);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    t_regs();
    t_status();
    t_frame(0, 2'b00, 0);
    t_frame(1, 2'b01, 1);
    t_frame(2, 2'b10, 0);
    t_frame(3, 2'b11, 1);
    wrap_up();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    fail_count++;
    wrap_up();
  end
endmodule
